// File: hdl/async_serial_unit.sv
`timescale 1ns/100ps
`include "serial_unit_consts.svh"
// Functional notes
// - tx status bit 1 is buffer full; next byte only once it reads 0.
// - tx status bit 0 is shift active; reinit only once it reads 0.
// - unread rx buffer at next arrival flags overrun; error status holds until the next char.
// - receiver checks exactly one stop bit whatever count is configured.
// - in continuous sending the full/shift pair goes 10, 01, 11, 01.
module async_serial_unit
(
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire serial_unit_pkg::addr_t reg_addr,
  input  wire serial_unit_pkg::byte_t reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output serial_unit_pkg::byte_t     reg_rdata,
  output logic                       irq,
  output logic                       txd,
  input  wire logic                  rxd
);
  import serial_unit_pkg::*;

  typedef enum logic [3:0]
  {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

  typedef struct packed
  {
    byte_t      tx_buf;
    logic       tx_full;
    logic       tx_shift;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [15:0] tx_cnt;
    rx_state_t  rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bits;
    byte_t      rx_sh;
    byte_t      rx_buf;
    logic       rx_unread;
    logic       rx_ovr;
    logic       rx_frm;
    logic [2:0] irq_st;
    logic [2:0] irq_mask;
    logic       two_stop;
    byte_t      rdata;
    logic       txd;
  } unit_state_t;

  unit_state_t s_q;
  unit_state_t s_d;
  logic        rx_level;
  logic        tx_done;
  logic        rx_done;
  logic        rx_err;

  // all checks below share this clock and reset
  default clocking dflt_cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  pin_sync u_rx_sync
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin     (rxd),
    .level   (rx_level)
  );

  // ====================
  // next state
  always_comb
  begin
    s_d = s_q;
    tx_done = 1'b0;
    rx_done = 1'b0;
    rx_err = 1'b0;
    // transmitter: buffer refills the shifter, so full/shift goes 10,01,11,01
    if (s_q.tx_shift)
    begin
      if (s_q.tx_cnt == `BIT_CYCLES - 16'd1)
      begin
        s_d.tx_cnt = 16'd0;
        s_d.txd = s_q.tx_sh[0];
        s_d.tx_sh = {1'b1, s_q.tx_sh[9:1]};
        if (s_q.tx_bits == 4'd0)
        begin
          // stop bit has gone out fully
          tx_done = 1'b1;
          s_d.tx_shift = 1'b0;
        end
        else
        begin
          s_d.tx_bits = s_q.tx_bits - 4'd1;
        end
      end
      else
      begin
        s_d.tx_cnt = s_q.tx_cnt + 16'd1;
      end
    end
    if (!s_d.tx_shift && s_q.tx_full)
    begin
      // load start, eight data, stop; one step more than bits sent, so
      // done lands once the last stop bit has stood a full bit time
      s_d.tx_sh = {1'b1, s_q.tx_buf, 1'b0};
      s_d.tx_bits = s_q.two_stop ? 4'd11 : 4'd10;
      // start bit leaves on the next edge, no dead bit before it
      s_d.tx_cnt = `BIT_CYCLES - 16'd1;
      s_d.tx_shift = 1'b1;
      s_d.tx_full = 1'b0;
    end
    // write while full is not guarded: data then undefined by contract
    if (reg_wr && reg_addr == `TX_BUFFER_ADDR)
    begin
      s_d.tx_buf = reg_wdata;
      s_d.tx_full = 1'b1;
    end
    // receiver
    unique case (s_q.rx_st)
      RX_IDLE:
      begin
        s_d.rx_cnt = 16'd0;
        if (!rx_level)
        begin
          s_d.rx_st = RX_START;
        end
      end
      RX_START:
      begin
        s_d.rx_cnt = s_q.rx_cnt + 16'd1;
        if (s_q.rx_cnt == (`BIT_CYCLES >> 1))
        begin
          s_d.rx_cnt = 16'd0;
          s_d.rx_bits = 3'd0;
          s_d.rx_st = rx_level ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        s_d.rx_cnt = s_q.rx_cnt + 16'd1;
        if (s_q.rx_cnt == `BIT_CYCLES - 16'd1)
        begin
          s_d.rx_cnt = 16'd0;
          s_d.rx_sh = {rx_level, s_q.rx_sh[7:1]};
          s_d.rx_bits = s_q.rx_bits + 3'd1;
          if (s_q.rx_bits == 3'd7)
          begin
            s_d.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        s_d.rx_cnt = s_q.rx_cnt + 16'd1;
        if (s_q.rx_cnt == `BIT_CYCLES - 16'd1)
        begin
          // only the first stop bit is sampled, any second is ignored
          s_d.rx_st = RX_IDLE;
          rx_done = 1'b1;
          s_d.rx_buf = s_q.rx_sh;
          s_d.rx_unread = 1'b1;
          s_d.rx_frm = !rx_level;
          s_d.rx_ovr = s_q.rx_unread;
          rx_err = !rx_level || s_q.rx_unread;
        end
      end
    endcase
    // reading the buffer clears unread; error flags stay until next char
    if (reg_rd && reg_addr == `RX_BUFFER_ADDR && !rx_done)
    begin
      s_d.rx_unread = 1'b0;
    end
    // interrupts: set wins over write-one-clear
    if (reg_wr && reg_addr == `IRQ_STATUS_ADDR)
    begin
      s_d.irq_st = s_q.irq_st & ~reg_wdata[2:0];
    end
    if (tx_done)
    begin
      s_d.irq_st[`IRQ_TX_DONE_BIT] = 1'b1;
    end
    if (rx_done)
    begin
      s_d.irq_st[`IRQ_RX_DONE_BIT] = 1'b1;
    end
    if (rx_err)
    begin
      s_d.irq_st[`IRQ_RX_ERR_BIT] = 1'b1;
    end
    if (reg_wr && reg_addr == `IRQ_MASK_ADDR)
    begin
      s_d.irq_mask = reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == `CONTROL_ADDR)
    begin
      s_d.two_stop = reg_wdata[`CTL_TWO_STOP_BIT];
    end
    // read data, one cycle after the strobe; unmapped reads zero
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `TX_BUFFER_ADDR:  s_d.rdata = s_q.tx_buf;
        `TX_STATUS_ADDR:  s_d.rdata = {6'h00, s_q.tx_full, s_q.tx_shift};
        `RX_BUFFER_ADDR:  s_d.rdata = s_q.rx_buf;
        `RX_ERROR_ADDR:   s_d.rdata = {6'h00, s_q.rx_frm, s_q.rx_ovr};
        `IRQ_STATUS_ADDR: s_d.rdata = {5'h00, s_q.irq_st};
        `IRQ_MASK_ADDR:   s_d.rdata = {5'h00, s_q.irq_mask};
        `CONTROL_ADDR:    s_d.rdata = {7'h00, s_q.two_stop};
        default:          s_d.rdata = 8'h00;
      endcase
    end
  end

  // ====================
  // state register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.rx_st <= RX_IDLE;
      s_q.txd <= 1'b1;
      s_q.tx_sh <= 10'h3ff;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign txd = s_q.txd;
  assign irq = |(s_q.irq_st & s_q.irq_mask);

  // ====================
  // checks; clock and reset come from the defaults at the top
  a_status_read: assert property (
    reg_rd && reg_addr == `TX_STATUS_ADDR |=>
      reg_rdata == {6'h00, $past(s_q.tx_full), $past(s_q.tx_shift)})
    else $error("tx status read mismatch");
  a_full_drains: assert property (
    s_q.tx_full && !s_q.tx_shift && !reg_wr |=> !s_q.tx_full && s_q.tx_shift)
    else $error("full buffer not moved to shifter");
  a_done_clears: assert property (
    tx_done && !s_q.tx_full |=> !s_q.tx_shift && s_q.irq_st[0])
    else $error("shift flag or done bit wrong after frame");
  // stop level must still be on the line when done fires
  a_done_shift: assert property (
    tx_done |-> s_q.tx_shift && s_q.tx_bits == 4'd0 && txd)
    else $error("done without finished frame");
  a_rx_overrun: assert property (
    rx_done && s_q.rx_unread |=> s_q.rx_ovr)
    else $error("overrun not flagged");
  a_stop_once: assert property (
    s_q.rx_st == RX_STOP && rx_done |=> s_q.rx_st == RX_IDLE)
    else $error("receiver waited for second stop bit");
  // irq may only rise after an event or a register write
  a_irq_level: assert property (
    $rose(irq) |-> $past(tx_done) || $past(rx_done) || $past(rx_err) ||
      $past(reg_wr))
    else $error("interrupt raised without a cause");
  a_write_full: assert property (
    reg_wr && reg_addr == `TX_BUFFER_ADDR |=> s_q.tx_full)
    else $error("write did not set full");
  c_tx_frame: cover property (@(posedge sys_clk) tx_done);
  c_tx_two: cover property (@(posedge sys_clk) tx_done && s_q.two_stop);
  c_tx_back: cover property (@(posedge sys_clk)
    s_q.tx_full && s_q.tx_shift);
  c_rx_ovr: cover property (@(posedge sys_clk) rx_done && s_q.rx_unread);
endmodule

// File: hdl/serial_unit_consts.svh
`ifndef SERIAL_UNIT_CONSTS_SVH
`define SERIAL_UNIT_CONSTS_SVH
// register map, word index on the plain port
`define TX_BUFFER_ADDR   4'h0
`define TX_STATUS_ADDR   4'h1
`define RX_BUFFER_ADDR   4'h2
`define RX_ERROR_ADDR    4'h3
`define IRQ_STATUS_ADDR  4'h4
`define IRQ_MASK_ADDR    4'h5
`define CONTROL_ADDR     4'h6
// tx status fields
`define TXS_SHIFT_BIT    0
`define TXS_FULL_BIT     1
// rx error fields
`define RXE_OVERRUN_BIT  0
`define RXE_FRAMING_BIT  1
// interrupt status fields
`define IRQ_TX_DONE_BIT  0
`define IRQ_RX_DONE_BIT  1
`define IRQ_RX_ERR_BIT   2
// control fields
`define CTL_TWO_STOP_BIT 0
// reset values
`define IRQ_MASK_RESET   8'h00
`define CONTROL_RESET    8'h00
// bit time in system clocks
`define BIT_CYCLES       16'd16
`endif

// File: hdl/serial_unit_pkg.sv
package serial_unit_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] addr_t;
endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/100ps
// three-stage pin synchroniser, change taken when stages 2 and 3 agree
module pin_sync
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed
  {
    logic [2:0] sh;
    logic       lvl;
  } sync_state_t;
  sync_state_t s_q;
  sync_state_t s_d;

  // ====================
  // sync chain
  // idle line is high, so reset to one
  always_comb
  begin
    s_d = s_q;
    s_d.sh = {s_q.sh[1:0], pin};
    if (s_q.sh[1] == s_q.sh[2])
    begin
      s_d.lvl = s_q.sh[2];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;
endmodule

// File: tb/serial_node.sv
`timescale 1ns/100ps
// remote node on the far end of the serial line
module serial_node
  import serial_unit_pkg::*;
#(
  parameter int BIT = 16
)
(
  input  wire logic sys_clk,
  input  wire logic txd,
  output logic      rxd,
  output byte_t     got,
  output logic      got_stop,
  output logic      got_stb
);
  logic [8:0] sh;
  // line idles high, as the node drives it to one
  initial
  begin
    rxd = 1'b1;
    got = 8'h00;
    got_stop = 1'b0;
    got_stb = 1'b0;
  end
  // one frame, lsb first; stop low makes a framing fault
  task automatic send(input byte_t v, input logic stop);
    logic [9:0] fr;
    fr = {stop, v, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      rxd <= fr[i];
      repeat (BIT - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    rxd <= 1'b1;
  endtask
  // mid-bit sampling, 8 data bits then one stop bit
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge sys_clk);
      sh = {txd, sh[8:1]};
    end
    got <= sh[7:0];
    got_stop <= sh[8];
    got_stb <= 1'b1;
    @(posedge sys_clk);
    got_stb <= 1'b0;
  end
endmodule

// File: tb/test_async_serial_unit.sv
`timescale 1ns/100ps
`include "serial_unit_consts.svh"
module test_async_serial_unit;
  import serial_unit_pkg::*;
  logic        sys_clk, sys_rst, reg_wr, reg_rd, irq, txd, rxd;
  logic        rd_seen, got_stop, got_stb;
  addr_t       reg_addr;
  byte_t       reg_wdata, reg_rdata, got, last_rd, a, b, c, d, f, g;
  logic [15:0] n;
  logic [15:0] notes[$];
  byte_t       frames[$];
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  // ==========================================
  // instances
  async_serial_unit i_async_serial_unit
  (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .irq       (irq),
    .txd       (txd),
    .rxd       (rxd)
  );
  serial_node #(.BIT(`BIT_CYCLES)) i_serial_node
  (
    .sys_clk  (sys_clk),
    .txd      (txd),
    .rxd      (rxd),
    .got      (got),
    .got_stop (got_stop),
    .got_stb  (got_stb)
  );
  // ==========================================
  // clock and helpers
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input byte_t seen, input byte_t exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input addr_t ad, input byte_t v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // let the edge's updates settle before the caller looks at outputs
    #1;
  endtask
  // mask 00 means the read is only for polling
  task automatic rd(input addr_t ad, input byte_t e, input byte_t m);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    notes.push_back({m, e});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_flag(input byte_t m, input byte_t v);
    for (int i = 0; i < 400; i++)
    begin
      rd(`TX_STATUS_ADDR, 8'h00, 8'h00);
      if ((last_rd & m) === v)
        return;
    end
    failures++;
  endtask
  // ==========================================
  // watcher: oldest note against each result
  always @(posedge sys_clk)
  begin
    rd_seen <= reg_rd;
    if (rd_seen)
    begin
      last_rd = reg_rdata;
      n = notes.pop_front();
      if (n[15:8] != 8'h00)
        chk(reg_rdata & n[15:8], n[7:0]);
    end
    if (got_stb)
    begin
      chk(got, frames.pop_front());
      chk({7'h00, got_stop}, 8'h01);
    end
  end
  // hang guard, run needs some 1250 cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    void'($urandom(23675));
    {a, b, c, d} = $urandom;
    {f, g} = 16'($urandom);
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`TX_STATUS_ADDR, 8'h00, 8'hff);
    rd(`IRQ_MASK_ADDR, 8'h00, 8'hff);
    rd(`CONTROL_ADDR, 8'h00, 8'hff);
    rd(4'hf, 8'h00, 8'hff);
    wr(`IRQ_MASK_ADDR, 8'h07);
    // back-to-back bytes, second loaded while the first shifts
    frames.push_back(a);
    wr(`TX_BUFFER_ADDR, a);
    repeat (4) @(posedge sys_clk);
    rd(`TX_STATUS_ADDR, 8'h01, 8'h03);
    frames.push_back(b);
    wr(`TX_BUFFER_ADDR, b);
    rd(`TX_STATUS_ADDR, 8'h03, 8'h03);
    wait_flag(8'h02, 8'h00);
    rd(`IRQ_STATUS_ADDR, 8'h01, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(`IRQ_STATUS_ADDR, 8'h01);
    rd(`TX_STATUS_ADDR, 8'h01, 8'h03);
    wait_flag(8'h03, 8'h00);
    repeat (4) @(posedge sys_clk);
    rd(`IRQ_STATUS_ADDR, 8'h01, 8'h01);
    wr(`IRQ_MASK_ADDR, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(`IRQ_STATUS_ADDR, 8'h07);
    wr(`IRQ_MASK_ADDR, 8'h07);
    chk({7'h00, irq}, 8'h00);
    chk(8'(frames.size()), 8'h00);
    // reception: clean, framing fault, then unread overrun
    i_serial_node.send(c, 1'b1);
    repeat (6) @(posedge sys_clk);
    rd(`RX_ERROR_ADDR, 8'h00, 8'h03);
    rd(`RX_BUFFER_ADDR, c, 8'hff);
    rd(`IRQ_STATUS_ADDR, 8'h02, 8'h06);
    i_serial_node.send(d, 1'b0);
    repeat (6) @(posedge sys_clk);
    rd(`RX_ERROR_ADDR, 8'h02, 8'h03);
    rd(`RX_BUFFER_ADDR, d, 8'hff);
    wr(`CONTROL_ADDR, 8'h01);
    i_serial_node.send(f, 1'b1);
    i_serial_node.send(g, 1'b1);
    repeat (6) @(posedge sys_clk);
    rd(`RX_ERROR_ADDR, 8'h01, 8'h03);
    rd(`RX_BUFFER_ADDR, g, 8'hff);
    // lone frame with two stop bits, loaded only on an idle unit
    rd(`TX_STATUS_ADDR, 8'h00, 8'hff);
    frames.push_back(c);
    wr(`TX_BUFFER_ADDR, c);
    // still shifting through the second stop bit
    repeat (170) @(posedge sys_clk);
    rd(`TX_STATUS_ADDR, 8'h01, 8'h03);
    wait_flag(8'h03, 8'h00);
    rd(`IRQ_STATUS_ADDR, 8'h01, 8'h01);
    chk(8'(frames.size()), 8'h00);
    give_verdict();
  end
endmodule
